// ---- inc/spio_pkg.sv ----
// Package for the shared parallel I/O port: register map, field layout, reset values.
// Assumes a 16-bit port reached over a plain strobe bus with word offsets.
`default_nettype none
package spio_pkg;
  localparam int unsigned SPIO_WIDTH = 16;
  localparam int unsigned SPIO_ADDR_W = 4;
  localparam logic [3:0] SPIO_OFS_DIRECTION = 4'h0;
  localparam logic [3:0] SPIO_OFS_PIN_LEVEL = 4'h1;
  localparam logic [3:0] SPIO_OFS_LATCH = 4'h2;
  localparam logic [3:0] SPIO_OFS_OPEN_DRAIN = 4'h3;
  localparam logic [3:0] SPIO_OFS_ANALOG = 4'h4;
  // Direction: 1 = input
  localparam logic [15:0] SPIO_RST_DIRECTION = 16'hffff;
  localparam logic [15:0] SPIO_RST_LATCH = 16'h0000;
  localparam logic [15:0] SPIO_RST_OPEN_DRAIN = 16'h0000;
  localparam logic [15:0] SPIO_RST_ANALOG = 16'h0000;
  localparam logic [15:0] SPIO_ZERO = 16'h0000;

  typedef struct packed {
    logic [15:0] out_data;
    logic [15:0] out_en;
  } spio_drive_s;

  typedef struct packed {
    logic [15:0] enable;
    logic [15:0] driving;
    logic [15:0] out_data;
    logic [15:0] input_only;
  } spio_periph_s;
endpackage
`default_nettype wire

// ---- logic/spio_pin_slice.sv ----
// One pin slice: output multiplexers, driver enable, open-drain and loop-through block.
// Assumes registers and the synchronised pin level are supplied by the port top.
`default_nettype none
module spio_pin_slice (
  // Port registers
  input  wire logic i_direction,
  input  wire logic i_latch,
  input  wire logic i_open_drain,
  input  wire logic i_implemented,
  // Peripheral side
  input  wire logic i_periph_enable,
  input  wire logic i_periph_driving,
  input  wire logic i_periph_out_data,
  input  wire logic i_periph_input_only,
  input  wire logic i_pad_in,
  // Outputs
  output logic      o_out_data,
  output logic      o_out_en,
  output logic      o_periph_in
);
  wire periph_owns = i_periph_enable & i_periph_driving & ~i_periph_input_only;
  wire port_data   = i_latch;
  wire port_en     = ~i_direction;
  wire mux_data    = periph_owns ? i_periph_out_data : port_data;
  wire mux_en      = periph_owns ? 1'b1 : port_en;
  // Open drain drives only the low level; a high releases the pin
  wire od_active   = i_open_drain & ~periph_owns;
  assign o_out_data = i_implemented & (od_active ? 1'b0 : mux_data);
  assign o_out_en   = i_implemented & (od_active ? (mux_en & ~mux_data) : mux_en);
  // The peripheral sees the pad only when the direction bit is input or the peripheral owns the pin
  assign o_periph_in = i_implemented & i_pad_in & ~(port_en & ~periph_owns);
endmodule
`default_nettype wire

// ---- logic/spio_port.sv ----
// Shared parallel I/O port top: register file over a strobe bus and sixteen pin slices.
// Assumes pins and peripheral signals are synchronous to i_ref_clk except the pads.
//
// Operation
// - Driving peripheral disables port driver; pin readable
// - Multiplexers pick peripheral or port ownership
// - Block port output looping into peripheral input
// - Direction one is input, zero output
// - Reset makes every pin an input
// - Latch reads latch, writes update latch
// - Pin-level reads pins, writes update latch
// - Unimplemented bits disabled and read zero
// - Input-only sharing leaves port full control
// - Open-drain drives low, releases for high
// - Analog pins read zero on pin level
//
// Added by the designer: the register offsets and strobed register access.
`default_nettype none
module spio_port
  import spio_pkg::*;
#(
  // Which port bits exist on this variant
  parameter logic [15:0] IMPLEMENTED_MASK = 16'hffff
) (
  // Clock and reset
  input  wire logic                   i_ref_clk,
  input  wire logic                   i_reset_n,
  // Register bus
  input  wire logic [SPIO_ADDR_W-1:0] i_addr,
  input  wire logic [SPIO_WIDTH-1:0]  i_wdata,
  input  wire logic                   i_wr,
  input  wire logic                   i_rd,
  output logic      [SPIO_WIDTH-1:0]  o_rdata,
  // Peripheral sharing
  input  wire spio_periph_s           i_periph,
  output logic      [SPIO_WIDTH-1:0]  o_periph_in,
  // Pads
  input  wire logic [SPIO_WIDTH-1:0]  i_pad,
  output logic      [SPIO_WIDTH-1:0]  o_pad,
  output logic      [SPIO_WIDTH-1:0]  o_pad_oe
);
  logic                  reset_n;
  logic [SPIO_WIDTH-1:0] pin_direction_register;
  logic [SPIO_WIDTH-1:0] output_latch_register;
  logic [SPIO_WIDTH-1:0] open_drain_select_register;
  logic [SPIO_WIDTH-1:0] analog_input_pin;
  logic [SPIO_WIDTH-1:0] pad_meta;
  logic [SPIO_WIDTH-1:0] pad_sync;
  logic [SPIO_WIDTH-1:0] pad_q;
  // Nets, since each pin slice drives its own bit of these
  wire spio_drive_s      drive;
  wire [SPIO_WIDTH-1:0]  periph_in_w;

  spio_reset_sync u_reset_sync (
    .i_ref_clk (i_ref_clk),
    .i_reset_n (i_reset_n),
    .o_reset_n (reset_n)
  );

  wire sel_dir   = (i_addr == SPIO_OFS_DIRECTION);
  wire sel_pin   = (i_addr == SPIO_OFS_PIN_LEVEL);
  wire sel_latch = (i_addr == SPIO_OFS_LATCH);
  wire sel_od    = (i_addr == SPIO_OFS_OPEN_DRAIN);
  wire sel_an    = (i_addr == SPIO_OFS_ANALOG);
  wire wr_dir    = i_wr & sel_dir;
  wire wr_latch  = i_wr & (sel_latch | sel_pin);
  wire wr_od     = i_wr & sel_od;
  wire wr_an     = i_wr & sel_an;
  wire [SPIO_WIDTH-1:0] wdata_m = i_wdata & IMPLEMENTED_MASK;

  always_ff @(posedge i_ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_direction_register     <= SPIO_RST_DIRECTION;
      output_latch_register      <= SPIO_RST_LATCH;
      open_drain_select_register <= SPIO_RST_OPEN_DRAIN;
      analog_input_pin           <= SPIO_RST_ANALOG;
    end else begin
      if (wr_dir) begin
        pin_direction_register <= wdata_m | ~IMPLEMENTED_MASK;
      end
      if (wr_latch) begin
        output_latch_register <= wdata_m;
      end
      if (wr_od) begin
        open_drain_select_register <= wdata_m;
      end
      if (wr_an) begin
        analog_input_pin <= wdata_m;
      end
    end
  end

  // Two-stage capture; only the second stage is observed
  always_ff @(posedge i_ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pad_meta <= SPIO_ZERO;
      pad_sync <= SPIO_ZERO;
    end else begin
      pad_meta <= i_pad;
      pad_sync <= pad_meta;
    end
  end
  assign pad_q = pad_sync;

  wire [SPIO_WIDTH-1:0] pin_view = pad_q & ~analog_input_pin & IMPLEMENTED_MASK;
  wire [SPIO_WIDTH-1:0] dir_view = pin_direction_register & IMPLEMENTED_MASK;
  wire [SPIO_WIDTH-1:0] rd_mux =
    sel_dir   ? dir_view :
    sel_pin   ? pin_view :
    sel_latch ? output_latch_register :
    sel_od    ? open_drain_select_register :
    sel_an    ? analog_input_pin : SPIO_ZERO;

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge i_ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      o_rdata <= SPIO_ZERO;
    end else begin
      o_rdata <= i_rd ? rd_mux : SPIO_ZERO;
    end
  end

  for (genvar g = 0; g < SPIO_WIDTH; g++) begin : g_slice
    spio_pin_slice u_slice (
      .i_direction         (pin_direction_register[g]),
      .i_latch             (output_latch_register[g]),
      .i_open_drain        (open_drain_select_register[g]),
      .i_implemented       (IMPLEMENTED_MASK[g]),
      .i_periph_enable     (i_periph.enable[g]),
      .i_periph_driving    (i_periph.driving[g]),
      .i_periph_out_data   (i_periph.out_data[g]),
      .i_periph_input_only (i_periph.input_only[g]),
      .i_pad_in            (pad_q[g]),
      .o_out_data          (drive.out_data[g]),
      .o_out_en            (drive.out_en[g]),
      .o_periph_in         (periph_in_w[g])
    );
  end

  // Drive is combinational from registers; a peripheral handover shows at once
  assign o_pad    = drive.out_data;
  assign o_pad_oe = drive.out_en;
  assign o_periph_in = periph_in_w;
endmodule
`default_nettype wire

// ---- logic/spio_reset_sync.sv ----
// Reset release synchroniser: asynchronous assertion, release after two clock edges.
// Assumes i_reset_n may be asynchronous to i_ref_clk.
`default_nettype none
module spio_reset_sync (
  // Clock and raw reset
  input  wire logic i_ref_clk,
  input  wire logic i_reset_n,
  // Synchronised reset
  output var  logic o_reset_n
);
  logic stage1;
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      stage1    <= 1'b0;
      o_reset_n <= 1'b0;
    end else begin
      stage1    <= 1'b1;
      o_reset_n <= stage1;
    end
  end
endmodule
`default_nettype wire

// ---- testbench/spio_pins.sv ----
// Board side of the port: pad level from the port driver or an outside source.
// Assumes the outside source drives every pin the port leaves undriven.
`default_nettype none
module spio_pins (
  // Port driver
  input  wire logic [15:0] i_pad,
  input  wire logic [15:0] i_pad_oe,
  // Outside source
  input  wire logic [15:0] i_ext,
  // Resolved level
  output logic      [15:0] o_level
);
  timeunit 1ns;
  timeprecision 100ps;
  // Released pins take the outside level, never a stale value
  assign o_level = (i_pad & i_pad_oe) | (i_ext & ~i_pad_oe);
endmodule
`default_nettype wire

// ---- testbench/spio_port_chk.sv ----
// Checker for the port top: pad ownership, read data, loop-through.
// Assumes only the top's ports; bound after the module.
`default_nettype none
module spio_port_chk
  import spio_pkg::*;
#(parameter logic [15:0] IMPLEMENTED_MASK = 16'hffff) (
  input wire logic         i_ref_clk,
  input wire logic         i_reset_n,
  input wire logic [3:0]   i_addr,
  input wire logic         i_rd,
  input wire logic [15:0]  o_rdata,
  input wire spio_periph_s i_periph,
  input wire logic [15:0]  o_periph_in,
  input wire logic [15:0]  i_pad,
  input wire logic [15:0]  o_pad,
  input wire logic [15:0]  o_pad_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);
  wire logic [15:0] own = i_periph.enable & i_periph.driving & ~i_periph.input_only
                          & IMPLEMENTED_MASK;
  wire logic [15:0] nm = ~IMPLEMENTED_MASK;
  sequence steady_pad; $stable(i_pad)[*3]; endsequence
  sequence pin_read; i_rd && i_addr == SPIO_OFS_PIN_LEVEL; endsequence
  a_periph_owns: assert property ((o_pad_oe & own) == own)
    else $error("owned pin not driven");
  a_periph_data: assert property (((o_pad ^ i_periph.out_data) & own) == 16'h0)
    else $error("owned pin data wrong");
  a_rdata_idle: assert property (o_rdata != 16'h0 |-> $past(i_rd))
    else $error("read data without read");
  a_rdata_mask: assert property ((o_rdata & nm) == 16'h0)
    else $error("missing bit read nonzero");
  a_pin_sync: assert property (steady_pad ##0 pin_read |=> (o_rdata & ~$past(i_pad)) == 0)
    else $error("pin read not pad");
  a_loop_block: assert property ((o_periph_in & o_pad_oe & ~own) == 16'h0)
    else $error("loop-through seen");
  a_missing_quiet: assert property ((((o_pad_oe & ~own) | o_periph_in) & nm) == 16'h0)
    else $error("missing bit active");
  a_reset_inputs: assert property ($rose(i_reset_n) |-> ((o_pad_oe & ~own) == 0)[*2])
    else $error("pin driven after reset");
endmodule
bind spio_port spio_port_chk #(.IMPLEMENTED_MASK(IMPLEMENTED_MASK)) spio_port_chk_inst (
  .i_ref_clk, .i_reset_n, .i_addr, .i_rd, .o_rdata, .i_periph, .o_periph_in, .i_pad, .o_pad,
  .o_pad_oe);
`default_nettype wire

// ---- testbench/testbench.sv ----
// Self-checking bench for the shared port: registers, pin ownership, pin reads.
// Assumes the port, its checker and the pad model are compiled first.
`default_nettype none
module testbench;
  import spio_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [15:0] MASK = 16'h7fff;
  logic i_ref_clk = 1'b0, i_reset_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [15:0] i_wdata = 16'h0, i_ext = 16'h0, pad, o_rdata, o_periph_in, o_pad, o_pad_oe;
  logic [15:0] dir = 16'hffff, lat = 16'h0, od = 16'h0, an = 16'h0, own, eoe;
  spio_periph_s i_periph = '0;
  int n_errors = 0, n_tests = 0;
  always #12.5 i_ref_clk = ~i_ref_clk;
  spio_port #(.IMPLEMENTED_MASK(MASK)) spio_port_inst (.i_ref_clk, .i_reset_n, .i_addr,
    .i_wdata, .i_wr, .i_rd, .o_rdata, .i_periph, .o_periph_in, .i_pad(pad), .o_pad, .o_pad_oe);
  spio_pins spio_pins_inst (.i_pad(o_pad), .i_pad_oe(o_pad_oe), .i_ext, .o_level(pad));
  assign own = i_periph.enable & i_periph.driving & ~i_periph.input_only & MASK;
  assign eoe = own | (~dir & ~(od & lat) & MASK);
  task automatic chk(input string what, input logic [15:0] e, g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_ref_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    if (a == SPIO_OFS_DIRECTION) dir = d | ~MASK;
    if (a == SPIO_OFS_PIN_LEVEL || a == SPIO_OFS_LATCH) lat = d & MASK;
    if (a == SPIO_OFS_OPEN_DRAIN) od = d & MASK;
    if (a == SPIO_OFS_ANALOG) an = d & MASK;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    logic [15:0] e;
    // A write always ends an edge before this strobe rises, so read-back sees it
    @(posedge i_ref_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    e = a == SPIO_OFS_DIRECTION ? dir & MASK : a == SPIO_OFS_LATCH ? lat :
        a == SPIO_OFS_PIN_LEVEL ? pad & ~an & MASK : a == SPIO_OFS_OPEN_DRAIN ? od :
        a == SPIO_OFS_ANALOG ? an : 16'h0;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    @(negedge i_ref_clk);
    chk("rdata", e, o_rdata);
  endtask
  // Three edges let the pad settle through the two-flop synchroniser
  task automatic pins;
    repeat (3) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    chk("pad_oe", eoe, o_pad_oe);
    chk("pad", ((i_periph.out_data & own) | (lat & ~od & ~own)) & eoe, o_pad & eoe);
    // An output-direction pin is blocked from the peripheral even when open drain releases it
    chk("periph_in", pad & (dir | own) & MASK, o_periph_in);
  endtask
  task automatic end_of_test;
    if (n_errors == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    void'($urandom(32'hd875ac67));
    repeat (8) @(posedge i_ref_clk);
    i_reset_n <= 1'b1;
    repeat (3) @(posedge i_ref_clk);
    rd(SPIO_OFS_DIRECTION);
    pins;
    for (int k = 0; k < 6; k++) begin
      @(posedge i_ref_clk);
      i_ext <= 16'($urandom);
      i_periph <= {$urandom, $urandom};
      wr(SPIO_OFS_LATCH, 16'($urandom));
      rd(SPIO_OFS_LATCH);
      wr(SPIO_OFS_PIN_LEVEL, 16'($urandom));
      rd(SPIO_OFS_LATCH);
      wr(SPIO_OFS_DIRECTION, 16'($urandom));
      wr(SPIO_OFS_OPEN_DRAIN, k[0] ? 16'($urandom) : 16'h0);
      wr(SPIO_OFS_ANALOG, 16'($urandom));
      pins;
      rd(SPIO_OFS_PIN_LEVEL);
      rd(SPIO_OFS_DIRECTION);
      rd(SPIO_OFS_OPEN_DRAIN);
      rd(SPIO_OFS_ANALOG);
      rd(4'h5);
    end
    @(posedge i_ref_clk);
    i_reset_n <= 1'b0;
    {dir, lat, od, an} = {16'hffff, 48'h0};
    repeat (2) @(posedge i_ref_clk);
    i_reset_n <= 1'b1;
    // The reset copy and the pad synchroniser both need edges before the pins settle
    repeat (3) @(posedge i_ref_clk);
    pins;
    rd(SPIO_OFS_LATCH);
    end_of_test;
  end
endmodule
`default_nettype wire
